// ===== rtl/uet_endpoint_transfer.sv
// Purpose: device endpoint transfer engine with endpoint buffers, pio and dma
// Assumes: link bytes and dma handshake come from logic on sys_clk
// Notes: crc is added and stripped by the link layer outside
//
// Contract
// - sixteen endpoints, each with its own buffer
// - device buffer memory is private storage
// - full in buffer is sent to host
// - emptied buffer raises interrupt for refill
// - buffers reachable by pio or dma
// - in token recognised from pid
// - address and endpoint checked before proceeding
// - in: full sends data, else nak
// - in waits for ack unless isochronous
// - ack updates status and interrupt
// - isochronous in interrupts right after sending
// - out token recognised from pid
// - out: empty stores data, else nak
// - out ack returned unless isochronous
// - out data updates status and interrupt
// - isochronous out interrupts on reception
// - dma only on endpoints one to fourteen
//
// The plain strobed port and the register addresses were left to the implementer.
`include "uet_params.svh"
`timescale 1ns/1ps
`default_nettype none
module uet_endpoint_transfer (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata_q,
  // interrupt level
  output logic irq_q,
  // received packet bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  // transmitted packet bytes
  input wire logic tx_ready,
  output logic tx_valid_q,
  output logic [7:0] tx_byte_q,
  output logic tx_last_q,
  // dma handshake
  input wire logic dma_ack,
  input wire logic dma_eot,
  input wire logic [7:0] dma_wdata,
  output logic dma_req_q,
  output logic [7:0] dma_rdata_q
);
  // private buffer store, 64 bytes per endpoint
  logic [7:0] mem [0:1023];
  // configuration and status
  logic [6:0] dev_addr_q;
  logic dev_en_q;
  logic [15:0] ep_en_q;
  logic [15:0] ep_iso_q;
  logic [15:0] ep_dir_q; // 1 = in
  logic [15:0] int_q; // sticky endpoint events
  logic [15:0] full_q; // buffer holds a packet
  logic [15:0] tog_q; // data toggle per endpoint
  logic [6:0] cnt_q [0:15]; // bytes in buffer
  logic [3:0] sel_q; // endpoint seen by pio
  logic [6:0] cpu_ptr_q;
  // dma handler
  logic [3:0] dma_ep_q;
  logic dma_en_q;
  logic [6:0] dma_ptr_q;
  // engine
  uet_pkg::uet_state_type st_q;
  logic [1:0] rx_idx_q; // byte index in packet, saturating
  logic tok_in_q;
  logic [6:0] tok_addr_q;
  logic tok_ep0_q;
  logic [3:0] tok_ep_q;
  logic store_q; // out data lands in buffer
  logic [6:0] eptr_q;
  logic [7:0] tmo_q;

  // register decode
  wire wr_ctrl = reg_we && (reg_addr == `UET_REG_CTRL);
  wire wr_epen = reg_we && (reg_addr == `UET_REG_EPEN);
  wire wr_episo = reg_we && (reg_addr == `UET_REG_EPISO);
  wire wr_epdir = reg_we && (reg_addr == `UET_REG_EPDIR);
  wire wr_int = reg_we && (reg_addr == `UET_REG_INT);
  wire wr_sel = reg_we && (reg_addr == `UET_REG_EPSEL);
  wire wr_data = reg_we && (reg_addr == `UET_REG_DATA);
  wire wr_cmd = reg_we && (reg_addr == `UET_REG_BUFCMD);
  wire wr_dma = reg_we && (reg_addr == `UET_REG_DMA);
  wire rd_data = reg_re && (reg_addr == `UET_REG_DATA);
  wire cpu_validate = wr_cmd && reg_wdata[`UET_CMD_VALIDATE];
  wire cpu_clear = wr_cmd && reg_wdata[`UET_CMD_CLEAR];
  wire cpu_room = cpu_ptr_q < `UET_EP_BYTES;
  // pio writes only into a buffer the engine does not own
  wire cpu_wr = wr_data && cpu_room && !full_q[sel_q];
  wire [7:0] cpu_byte = mem[{sel_q, cpu_ptr_q[5:0]}];

  // dma: only endpoints one to fourteen may use it
  wire dma_ep_ok = (dma_ep_q >= `UET_DMA_FIRST_EP) && (dma_ep_q <= `UET_DMA_LAST_EP);
  wire dma_in = ep_dir_q[dma_ep_q];
  wire dma_need = dma_in ? !full_q[dma_ep_q] : full_q[dma_ep_q];
  wire dma_go = dma_en_q && dma_ep_ok && ep_en_q[dma_ep_q] && dma_need;
  wire dma_xfer = dma_req_q && dma_ack && dma_go;
  wire [6:0] dma_ptr_nx = dma_ptr_q + `UET_PTR_ONE;
  wire dma_in_full = dma_xfer && dma_in && (dma_ptr_nx == `UET_EP_BYTES);
  wire dma_out_done = dma_xfer && !dma_in && (dma_ptr_nx >= cnt_q[dma_ep_q]);
  wire dma_validate = dma_xfer && dma_in && (dma_in_full || dma_eot);
  wire dma_clear = dma_xfer && !dma_in && (dma_out_done || dma_eot);
  wire dma_wr = dma_xfer && dma_in;

  // one local write port; dma wins over pio in the same cycle
  wire loc_we = dma_wr || cpu_wr;
  wire [9:0] loc_idx = dma_wr ? {dma_ep_q, dma_ptr_q[5:0]} : {sel_q, cpu_ptr_q[5:0]};
  wire [7:0] loc_byte = dma_wr ? dma_wdata : reg_wdata[7:0];

  // engine events
  wire tx_fire = tx_valid_q && tx_ready;
  wire rx_first = rx_valid && (rx_idx_q == 2'h0);
  wire is_tok = (rx_byte == `UET_PID_IN) || (rx_byte == `UET_PID_OUT);
  wire is_data = (rx_byte == `UET_PID_DATA0) || (rx_byte == `UET_PID_DATA1);
  wire [3:0] tok_ep_w = {rx_byte[2:0], tok_ep0_q};
  wire tok_end = (st_q == uet_pkg::ST_TOK) && rx_valid && (rx_idx_q == 2'h2);
  // endpoint zero serves both directions
  wire dir_ok = (tok_ep_w == `UET_RST4) || (ep_dir_q[tok_ep_w] == tok_in_q);
  wire tok_ok = dev_en_q && (tok_addr_q == dev_addr_q) && ep_en_q[tok_ep_w] && dir_ok;
  wire tok_iso = ep_iso_q[tok_ep_q];
  wire in_done = (st_q == uet_pkg::ST_SEND) && tx_fire && tx_last_q;
  wire ack_rx = (st_q == uet_pkg::ST_WACK) && rx_first && (rx_byte == `UET_PID_ACK);
  wire odat_bad = (st_q == uet_pkg::ST_ODAT) && rx_first && !is_data;
  wire out_wr = (st_q == uet_pkg::ST_ODAT) && rx_valid && (rx_idx_q != 2'h0) && store_q &&
                (eptr_q < `UET_EP_BYTES);
  wire out_end = (st_q == uet_pkg::ST_ODAT) && rx_valid && rx_last && !odat_bad;
  wire eng_clr_full = (in_done && tok_iso) || ack_rx;
  wire eng_set_full = out_end && store_q;
  wire [6:0] out_cnt = eptr_q + {6'h00, out_wr};
  wire [6:0] eptr_nx = eptr_q + `UET_PTR_ONE;

  // per-endpoint set and clear vectors; a set beats a clear
  wire [15:0] tok_bit = 16'h0001 << tok_ep_q;
  wire [15:0] sel_bit = 16'h0001 << sel_q;
  wire [15:0] dma_bit = 16'h0001 << dma_ep_q;
  wire [15:0] full_set = (eng_set_full ? tok_bit : `UET_RST16) | (cpu_validate ? sel_bit : `UET_RST16) |
                         (dma_validate ? dma_bit : `UET_RST16);
  wire [15:0] full_clr = (eng_clr_full ? tok_bit : `UET_RST16) | (cpu_clear ? sel_bit : `UET_RST16) |
                         (dma_clear ? dma_bit : `UET_RST16);
  wire [15:0] int_set = (eng_clr_full || eng_set_full) ? tok_bit : `UET_RST16;
  wire [15:0] int_w1c = wr_int ? reg_wdata : `UET_RST16;
  wire tog_flip = ack_rx || (eng_set_full && !tok_iso);

  // read mux
  wire [15:0] stat_w = {4'h0, tog_q[sel_q], ep_iso_q[sel_q], ep_dir_q[sel_q], ep_en_q[sel_q],
                        full_q[sel_q], cnt_q[sel_q]};
  logic [15:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr)
      `UET_REG_CTRL: rd_mux = {7'h00, dev_en_q, 1'b0, dev_addr_q};
      `UET_REG_EPEN: rd_mux = ep_en_q;
      `UET_REG_EPISO: rd_mux = ep_iso_q;
      `UET_REG_EPDIR: rd_mux = ep_dir_q;
      `UET_REG_INT: rd_mux = int_q;
      `UET_REG_EPSEL: rd_mux = {12'h000, sel_q};
      `UET_REG_EPSTAT: rd_mux = stat_w;
      `UET_REG_DATA: rd_mux = {8'h00, cpu_byte};
      `UET_REG_DMA: rd_mux = {11'h000, dma_en_q, dma_ep_q};
      default: rd_mux = `UET_RST16; // unmapped reads as zero
    endcase
  end

  // register port answer, one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_q <= `UET_RST16;
    else if (ce)
      reg_rdata_q <= reg_re ? rd_mux : `UET_RST16;
  end

  // software configuration
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dev_addr_q <= `UET_RST7;
      dev_en_q <= 1'b0;
      ep_en_q <= `UET_RST16;
      ep_iso_q <= `UET_RST16;
      ep_dir_q <= `UET_RST16;
      sel_q <= `UET_RST4;
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        dev_addr_q <= reg_wdata[6:0];
        dev_en_q <= reg_wdata[`UET_CTRL_DEVEN];
      end
      if (wr_epen)
        ep_en_q <= reg_wdata;
      if (wr_episo)
        ep_iso_q <= reg_wdata;
      if (wr_epdir)
        ep_dir_q <= reg_wdata;
      if (wr_sel)
        sel_q <= reg_wdata[3:0];
    end
  end

  // endpoint status, toggles and interrupt flags
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      full_q <= `UET_RST16;
      int_q <= `UET_RST16;
      tog_q <= `UET_RST16;
      irq_q <= 1'b0;
      for (int i = 0; i < `UET_NUM_EP; i++)
        cnt_q[i] <= `UET_RST7;
    end
    else if (ce)
    begin
      full_q <= (full_q & ~full_clr) | full_set;
      int_q <= (int_q & ~int_w1c) | int_set;
      irq_q <= |int_q;
      if (tog_flip)
        tog_q <= tog_q ^ tok_bit;
      // byte counts follow whoever filled the buffer
      if (eng_set_full)
        cnt_q[tok_ep_q] <= out_cnt;
      if (dma_validate)
        cnt_q[dma_ep_q] <= dma_ptr_nx;
      else if (cpu_validate)
        cnt_q[sel_q] <= cpu_ptr_q;
    end
  end

  // pio pointer: restarts on select and on buffer commands
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cpu_ptr_q <= `UET_RST7;
    else if (ce)
    begin
      if (wr_sel || wr_cmd)
        cpu_ptr_q <= `UET_RST7;
      else if ((cpu_wr || rd_data) && cpu_room)
        cpu_ptr_q <= cpu_ptr_q + `UET_PTR_ONE;
    end
  end

  // dma handler; termination disables it until re-enabled
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dma_en_q <= 1'b0;
      dma_ep_q <= `UET_RST4;
      dma_ptr_q <= `UET_RST7;
      dma_req_q <= 1'b0;
      dma_rdata_q <= `UET_RST8;
    end
    else if (ce)
    begin
      if (wr_dma)
      begin
        dma_en_q <= reg_wdata[`UET_DMA_EN];
        dma_ep_q <= reg_wdata[3:0];
        dma_ptr_q <= `UET_RST7;
      end
      else if (dma_xfer)
      begin
        dma_ptr_q <= (dma_validate || dma_clear) ? `UET_RST7 : dma_ptr_nx;
        if (dma_eot || dma_clear)
          dma_en_q <= 1'b0;
      end
      if (dma_xfer && !dma_in)
        dma_rdata_q <= mem[{dma_ep_q, dma_ptr_q[5:0]}];
      // drop request after a buffer boundary so status can settle
      dma_req_q <= dma_go && !dma_validate && !dma_clear && !wr_dma;
    end
  end

  // buffer writes: engine port and local port
  always_ff @(posedge sys_clk)
  begin
    if (ce)
    begin
      if (out_wr)
        mem[{tok_ep_q, eptr_q[5:0]}] <= rx_byte;
      if (loc_we)
        mem[loc_idx] <= loc_byte;
    end
  end

  // received byte position within a packet
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rx_idx_q <= 2'h0;
    else if (ce && rx_valid)
      rx_idx_q <= rx_last ? 2'h0 : ((rx_idx_q == 2'h3) ? 2'h3 : rx_idx_q + 2'h1);
  end

  // serial interface engine
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= uet_pkg::ST_IDLE;
      tok_in_q <= 1'b0;
      tok_addr_q <= `UET_RST7;
      tok_ep0_q <= 1'b0;
      tok_ep_q <= `UET_RST4;
      store_q <= 1'b0;
      eptr_q <= `UET_RST7;
      tmo_q <= `UET_RST8;
      tx_valid_q <= 1'b0;
      tx_byte_q <= `UET_RST8;
      tx_last_q <= 1'b0;
    end
    else if (ce)
    begin
      unique case (st_q)
        // wait for the first byte of a token
        uet_pkg::ST_IDLE:
          if (rx_first && is_tok && !rx_last)
          begin
            tok_in_q <= (rx_byte == `UET_PID_IN);
            st_q <= uet_pkg::ST_TOK;
          end
        // collect address and endpoint, then decide
        uet_pkg::ST_TOK:
          if (rx_valid && rx_idx_q == 2'h1)
          begin
            tok_addr_q <= rx_byte[6:0];
            tok_ep0_q <= rx_byte[7];
            if (rx_last)
              st_q <= uet_pkg::ST_IDLE;
          end
          else if (tok_end)
          begin
            tok_ep_q <= tok_ep_w;
            eptr_q <= `UET_RST7;
            store_q <= !full_q[tok_ep_w];
            if (!tok_ok || !rx_last)
              st_q <= uet_pkg::ST_IDLE;
            else if (!tok_in_q)
              st_q <= uet_pkg::ST_ODAT;
            else if (full_q[tok_ep_w])
            begin
              tx_valid_q <= 1'b1;
              tx_byte_q <= tog_q[tok_ep_w] ? `UET_PID_DATA1 : `UET_PID_DATA0;
              tx_last_q <= (cnt_q[tok_ep_w] == `UET_RST7);
              st_q <= uet_pkg::ST_SEND;
            end
            else
            begin
              tx_valid_q <= 1'b1;
              tx_byte_q <= `UET_PID_NAK;
              tx_last_q <= 1'b1;
              st_q <= uet_pkg::ST_HS;
            end
          end
        // stream the buffer out behind the data pid
        uet_pkg::ST_SEND:
          if (tx_fire)
          begin
            if (tx_last_q)
            begin
              tx_valid_q <= 1'b0;
              tmo_q <= 8'(`UET_ACK_TMO_CYC);
              st_q <= tok_iso ? uet_pkg::ST_IDLE : uet_pkg::ST_WACK;
            end
            else
            begin
              tx_byte_q <= mem[{tok_ep_q, eptr_q[5:0]}];
              tx_last_q <= (eptr_nx == cnt_q[tok_ep_q]);
              eptr_q <= eptr_nx;
            end
          end
        // a lost ack leaves the buffer full for a retry
        uet_pkg::ST_WACK:
          if (rx_first || tmo_q == `UET_RST8)
            st_q <= uet_pkg::ST_IDLE;
          else
            tmo_q <= tmo_q - 8'h01;
        // receive the data phase of an out transfer
        uet_pkg::ST_ODAT:
          if (odat_bad)
            st_q <= rx_last ? uet_pkg::ST_IDLE : uet_pkg::ST_SKIP;
          else if (rx_valid)
          begin
            if (out_wr)
              eptr_q <= eptr_nx;
            if (rx_last && tok_iso)
              st_q <= uet_pkg::ST_IDLE;
            else if (rx_last)
            begin
              tx_valid_q <= 1'b1;
              tx_byte_q <= store_q ? `UET_PID_ACK : `UET_PID_NAK;
              tx_last_q <= 1'b1;
              st_q <= uet_pkg::ST_HS;
            end
          end
        // single handshake byte
        uet_pkg::ST_HS:
          if (tx_fire)
          begin
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            st_q <= uet_pkg::ST_IDLE;
          end
        // drop the rest of an unexpected packet
        uet_pkg::ST_SKIP:
          if (rx_valid && rx_last)
            st_q <= uet_pkg::ST_IDLE;
        default:
          st_q <= uet_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : uet_endpoint_transfer
`default_nettype wire

// ===== rtl/uet_params.svh
// Purpose: named constants of the endpoint transfer block
// Assumes: 16-bit register port, 4-bit word index
// Notes: definitions only
`ifndef UET_PARAMS_SVH
`define UET_PARAMS_SVH
// endpoint buffer geometry
`define UET_NUM_EP 16
`define UET_EP_BYTES 7'h40
`define UET_PTR_ONE 7'h01
// register word indexes
`define UET_REG_CTRL 4'h0
`define UET_REG_EPEN 4'h1
`define UET_REG_EPISO 4'h2
`define UET_REG_EPDIR 4'h3
`define UET_REG_INT 4'h4
`define UET_REG_EPSEL 4'h5
`define UET_REG_EPSTAT 4'h6
`define UET_REG_DATA 4'h7
`define UET_REG_BUFCMD 4'h8
`define UET_REG_DMA 4'h9
// field positions
`define UET_CTRL_DEVEN 8
`define UET_DMA_EN 4
`define UET_CMD_VALIDATE 0
`define UET_CMD_CLEAR 1
// reset values
`define UET_RST16 16'h0000
`define UET_RST8 8'h00
`define UET_RST7 7'h00
`define UET_RST4 4'h0
// endpoints that may use the dma handler
`define UET_DMA_FIRST_EP 4'h1
`define UET_DMA_LAST_EP 4'hE
// packet identifiers, full byte with check nibble
`define UET_PID_OUT 8'hE1
`define UET_PID_IN 8'h69
`define UET_PID_DATA0 8'hC3
`define UET_PID_DATA1 8'h4B
`define UET_PID_ACK 8'hD2
`define UET_PID_NAK 8'h5A
// timing
`define UET_CLK_PERIOD_NS 10
`define UET_ACK_TMO_NS 1500
`define UET_ACK_TMO_CYC (`UET_ACK_TMO_NS / `UET_CLK_PERIOD_NS)
`endif

// ===== rtl/uet_pkg.sv
// Purpose: types of the endpoint transfer block
// Assumes: constants live in uet_params.svh
// Notes: one-hot engine states
package uet_pkg;
  // serial interface engine states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_TOK = 7'h02,
    ST_SEND = 7'h04,
    ST_WACK = 7'h08,
    ST_ODAT = 7'h10,
    ST_HS = 7'h20,
    ST_SKIP = 7'h40
  } uet_state_type;
endpackage : uet_pkg

// ===== sim/tb.sv
// Purpose: self-checking bench of the endpoint transfer block
// Assumes: ce high apart from one freeze check, host model on the link
// Notes: payloads random from a fixed seed
`include "uet_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  // bench driven inputs
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1; // lowered once to prove the freeze
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic dma_ack = 1'b0;
  logic dma_eot = 1'b0;
  logic [7:0] dma_wdata = 8'h00;
  // design outputs and link wires
  logic [15:0] reg_rdata_q;
  logic irq_q, rx_valid, rx_last, tx_ready, tx_valid_q, tx_last_q, dma_req_q;
  logic [7:0] rx_byte, tx_byte_q, dma_rdata_q;
  // bookkeeping
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'h629a;
  int n;
  logic [15:0] v;
  logic [7:0] e[$]; // expected reply
  logic [7:0] dat[$]; // payload sent
  localparam logic [6:0] dev_adr = 7'h15; // our bus address
  always #5 sys_clk = ~sys_clk;
  uet_endpoint_transfer u_dut (.*);
  uet_host_model u_host (.*);
  // data identifier from the toggle
  function automatic logic [7:0] dpid(input logic t);
    return t ? `UET_PID_DATA1 : `UET_PID_DATA0;
  endfunction : dpid
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask : wr
  // read data is taken one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata_q;
  endtask : rd
  // wait for a reply and compare, or stay silent when e is empty
  task automatic pkt(input int n0);
    repeat (200)
    begin
      @(posedge sys_clk);
      if (u_host.npk != n0)
        break;
    end
    chk(16'(u_host.npk - n0), 16'(e.size() != 0));
    if (e.size() != 0)
    begin
      chk(16'(u_host.q.size()), 16'(e.size()));
      foreach (e[i])
        chk(u_host.q[i], e[i]);
    end
  endtask : pkt
  // interrupt up, flag read, cleared by writing it back
  task automatic irqchk(input logic [15:0] m);
    repeat (4) @(posedge sys_clk);
    #1 chk(irq_q, 1'b1);
    rd(`UET_REG_INT, v);
    chk(v, m);
    wr(`UET_REG_INT, m);
    repeat (3) @(posedge sys_clk);
    #1 chk(irq_q, 1'b0);
  endtask : irqchk
  // pio fill of an in buffer, builds the expected data packet
  task automatic fill(input logic [3:0] ep, input logic t);
    int len;
    len = 1 + ($unsigned($random(seed)) % 8);
    e = {dpid(t)};
    wr(`UET_REG_EPSEL, {12'h000, ep});
    repeat (len)
    begin
      e.push_back(8'($random(seed)));
      wr(`UET_REG_DATA, {8'h00, e[$]});
    end
    wr(`UET_REG_BUFCMD, 16'h0001);
  endtask : fill
  // host sends out token and a random data packet
  task automatic out_pkt(input logic [3:0] ep);
    int len;
    len = 1 + ($unsigned($random(seed)) % 8);
    dat = {};
    n = u_host.npk;
    u_host.tok(`UET_PID_OUT, dev_adr, ep);
    u_host.put(`UET_PID_DATA0, 1'b0);
    repeat (len)
    begin
      dat.push_back(8'($random(seed)));
      u_host.put(dat[$], dat.size() == len);
    end
  endtask : out_pkt
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // hang guard, well beyond the thousand or so cycles the tests need
  initial
  begin
    #500000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    // reset values, unmapped index, setup
    rd(`UET_REG_EPEN, v);
    chk(v, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, v);
    chk(v, 16'h0000);
    wr(`UET_REG_CTRL, {7'h00, 1'b1, 1'b0, dev_adr});
    wr(`UET_REG_EPEN, 16'h7FFF); // ep15 left off
    wr(`UET_REG_EPISO, 16'h0018); // ep3, ep4 iso
    wr(`UET_REG_EPDIR, 16'h002A); // ep1, ep3, ep5 in
    rd(`UET_REG_EPEN, v);
    chk(v, 16'h7FFF);
    // a write taken while the block is frozen must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(`UET_REG_EPSEL, 16'h0009);
    ce <= 1'b1;
    rd(`UET_REG_EPSEL, v);
    chk(v, 16'h0000);
    $display("test 1 done");
    // empty in buffer, then foreign address and disabled endpoint
    n = u_host.npk;
    u_host.tok(`UET_PID_IN, dev_adr, 4'h1);
    e = {`UET_PID_NAK};
    pkt(n);
    for (int k = 0; k < 2; k++)
    begin
      n = u_host.npk;
      u_host.tok(`UET_PID_IN, k ? dev_adr : dev_adr ^ 7'h01, k ? 4'hF : 4'h1);
      e = {};
      pkt(n);
      #1 chk(irq_q, 1'b0);
    end
    $display("test 2 done");
    // two in transfers on ep1, toggle flips, second with link stalls
    for (int k = 0; k < 2; k++)
    begin
      u_host.slow = k[0];
      fill(4'h1, k[0]);
      n = u_host.npk;
      u_host.tok(`UET_PID_IN, dev_adr, 4'h1);
      pkt(n);
      u_host.put(`UET_PID_ACK, 1'b1);
      irqchk(16'h0002);
      rd(`UET_REG_EPSTAT, v);
      chk(v & 16'h0880, k ? 16'h0000 : 16'h0800);
    end
    // iso in needs no handshake
    fill(4'h3, 1'b0);
    n = u_host.npk;
    u_host.tok(`UET_PID_IN, dev_adr, 4'h3);
    pkt(n);
    irqchk(16'h0008);
    $display("test 3 done");
    // out on ep2: ack, status, drain, nak while full, clear
    out_pkt(4'h2);
    e = {`UET_PID_ACK};
    pkt(n);
    irqchk(16'h0004);
    wr(`UET_REG_EPSEL, 16'h0002);
    rd(`UET_REG_EPSTAT, v);
    chk(v & 16'h00FF, {8'h00, 1'b1, 7'(dat.size())});
    wr(`UET_REG_EPSEL, 16'h0002);
    foreach (dat[i])
    begin
      rd(`UET_REG_DATA, v);
      chk(v, {8'h00, dat[i]});
    end
    out_pkt(4'h2);
    e = {`UET_PID_NAK};
    pkt(n);
    wr(`UET_REG_BUFCMD, 16'h0002);
    rd(`UET_REG_EPSTAT, v);
    chk(v & 16'h0080, 16'h0000);
    // iso out: stored without handshake
    out_pkt(4'h4);
    e = {};
    pkt(n);
    irqchk(16'h0010);
    $display("test 4 done");
    // dma: ep0 never asks, ep5 filled by dma and sent
    wr(`UET_REG_DMA, 16'h0010);
    repeat (10) @(posedge sys_clk);
    #1 chk(dma_req_q, 1'b0);
    wr(`UET_REG_DMA, 16'h0015);
    repeat (20)
    begin
      @(posedge sys_clk);
      if (dma_req_q)
        break;
    end
    chk(dma_req_q, 1'b1);
    e = {dpid(1'b0)};
    for (int i = 0; i < 3; i++)
    begin
      e.push_back(8'($random(seed)));
      dma_ack <= 1'b1;
      dma_wdata <= e[$];
      dma_eot <= (i == 2);
      @(posedge sys_clk);
    end
    dma_ack <= 1'b0;
    dma_eot <= 1'b0;
    n = u_host.npk;
    u_host.tok(`UET_PID_IN, dev_adr, 4'h5);
    pkt(n);
    u_host.put(`UET_PID_ACK, 1'b1);
    irqchk(16'h0020);
    // dma drains the iso out packet still held by ep4, then the buffer is free
    wr(`UET_REG_DMA, 16'h0014);
    repeat (3) @(posedge sys_clk);
    chk(dma_req_q, 1'b1);
    dma_ack <= 1'b1;
    foreach (dat[i])
    begin
      @(posedge sys_clk);
      if (i == dat.size() - 1)
        dma_ack <= 1'b0;
      #1 chk(dma_rdata_q, {8'h00, dat[i]});
    end
    wr(`UET_REG_EPSEL, 16'h0004);
    rd(`UET_REG_EPSTAT, v);
    chk(v & 16'h0080, 16'h0000);
    $display("test 5 done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// ===== sim/uet_chk.sv
// Purpose: port checks of the endpoint transfer block
// Assumes: one clock, ce high in normal use
// Notes: bound onto the design top below
`include "uet_params.svh"
`timescale 1ns/1ps
`default_nettype none
module uet_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [15:0] reg_rdata_q,
  input wire logic irq_q,
  // link bytes
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic tx_ready,
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_byte_q,
  input wire logic tx_last_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // read data only in the cycle after a read
  rdata_idle_a:
    assert property ($past(ce) && !$past(reg_re) |-> reg_rdata_q == 16'h0000)
    else $error("read data not idle");
  // an offered byte waits for the link
  tx_hold_a:
    assert property (ce && tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_byte_q) && $stable(tx_last_q))
    else $error("tx byte changed while stalled");
  // a packet ends only after its last byte went out
  tx_end_a:
    assert property ($fell(tx_valid_q) |-> $past(tx_ready && tx_last_q))
    else $error("tx packet cut short");
  // every reply follows the end of a received packet
  reply_cause_a:
    assert property ($rose(tx_valid_q) |-> $past(rx_valid && rx_last))
    else $error("reply without a packet");
  // a reply opens with a data or handshake identifier
  first_pid_a:
    assert property ($rose(tx_valid_q) |->
      tx_byte_q inside {`UET_PID_DATA0, `UET_PID_DATA1, `UET_PID_ACK, `UET_PID_NAK})
    else $error("bad reply identifier");
  // handshakes are single bytes
  hs_single_a:
    assert property ($rose(tx_valid_q) && (tx_byte_q == `UET_PID_ACK || tx_byte_q == `UET_PID_NAK) |-> tx_last_q)
    else $error("handshake longer than a byte");
  // interrupt rises only after a packet event
  irq_set_a:
    assert property ($rose(irq_q) |-> $past(rx_valid && rx_last, 2) || $past(rx_valid && rx_last, 3)
      || $past(tx_valid_q && tx_ready && tx_last_q, 2) || $past(tx_valid_q && tx_ready && tx_last_q, 3))
    else $error("interrupt without cause");
  // interrupt falls only after a clearing write
  irq_clr_a:
    assert property ($fell(irq_q) |-> $past(reg_we, 2))
    else $error("interrupt fell without a write");
endmodule : uet_chk
bind uet_endpoint_transfer uet_chk u_chk (.*);
`default_nettype wire

// ===== sim/uet_host_model.sv
// Purpose: behavioural usb host on the link side
// Assumes: byte level link, crc handled elsewhere
// Notes: slow mode holds tx ready low every other cycle
`timescale 1ns/1ps
`default_nettype none
module uet_host_model (
  // clock
  input wire logic sys_clk,
  // bytes from the device
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_byte_q,
  input wire logic tx_last_q,
  output logic tx_ready,
  // bytes to the device
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_last
);
  logic slow = 1'b0; // set by the bench for stalls
  logic [7:0] q[$]; // bytes of the latest reply
  int npk = 0; // replies completed
  bit fin = 1'b1; // next byte starts a packet
  initial
  begin
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_byte = 8'hA5;
    tx_ready = 1'b1;
  end
  // ready toggles when slow, so bytes wait a cycle
  always @(posedge sys_clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
  // collect reply bytes
  always @(posedge sys_clk)
    if (tx_valid_q && tx_ready)
    begin
      if (fin)
        q.delete();
      fin = tx_last_q;
      q.push_back(tx_byte_q);
      if (tx_last_q)
        npk++;
    end
  // one byte, then the line shows the inverse so no stale value passes
  task automatic put(input logic [7:0] b, input logic l);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    rx_last <= l;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_byte <= ~b;
  endtask : put
  // token: pid, address with ep bit 0, ep bits 3:1 ending the packet
  task automatic tok(input logic [7:0] pid, input logic [6:0] adr, input logic [3:0] ep);
    put(pid, 1'b0);
    put({ep[0], adr}, 1'b0);
    put({5'h00, ep[3:1]}, 1'b1);
  endtask : tok
endmodule : uet_host_model
`default_nettype wire
